/* File: rtl/conflict_instruction_cache.sv */
// What this block does
// - conflict when address-stage pm access meets fetch1
// - data access wins, colliding fetch postponed
// - stall only when fetched instruction misses
// - cache the colliding fetch, not the accessor
// - lookup only on a program-memory data access that meets fetch1
// - hit supplies instruction with no delay cycle
// - miss refetches next cycle, one stall
// - fill only when enabled and not frozen
// - 32 entries as 16 sets of two ways
// - set index is address bits 3 to 0
// - every entry carries its own valid bit
// - per-set bit names way not last used
// - compare both ways' stored addresses on lookup
// - hit points replacement bit at other way
// - miss fills named way then toggles bit
// - flush clears all valids, one cycle latency
// - hit on pending fill forwards load input
`timescale 1ns/10ps
`default_nettype none

module conflict_instruction_cache #(
   parameter int unsigned ADDR_W = conflict_cache_pkg::DEF_ADDR_W,
   parameter int unsigned INSTR_W = conflict_cache_pkg::DEF_INSTR_W
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite register slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // sequencer side
   input wire logic fetch1_req,
   input wire logic [ADDR_W-1:0] fetch1_addr,
   input wire logic addr_stage_pm_access,
   input wire logic flush_cache,
   output logic data_priority,
   output logic fetch_postpone,
   output logic pipe_stall,
   output logic refetch_req,
   output logic [ADDR_W-1:0] refetch_addr,
   output logic cache_instr_valid,
   output logic [INSTR_W-1:0] cache_instr,
   // instruction load bus from program memory
   input wire logic load_valid,
   input wire logic [INSTR_W-1:0] load_instr
);

   // ***************************************
   // elaboration checks
   // ***************************************
   if (ADDR_W <= conflict_cache_pkg::SET_IDX_W) begin : g_bad_addr
      $error("ADDR_W must exceed the set index width");
   end
   if (INSTR_W < 1) begin : g_bad_instr
      $error("INSTR_W must be at least one");
   end

   localparam int unsigned SETS = conflict_cache_pkg::NUM_SETS;
   localparam int unsigned IW = conflict_cache_pkg::SET_IDX_W;

   // ***************************************
   // storage
   // ***************************************
   logic [ADDR_W-1:0] tag0_r [SETS];
   logic [ADDR_W-1:0] tag1_r [SETS];
   logic [INSTR_W-1:0] data0_r [SETS];
   logic [INSTR_W-1:0] data1_r [SETS];
   logic [SETS-1:0] valid0_r;
   logic [SETS-1:0] valid1_r;
   logic [SETS-1:0] lru_r;

   logic enable_r;
   logic freeze_r;
   logic flush_sw_r;
   logic pend_r;
   logic pend_way_r;
   logic [ADDR_W-1:0] pend_addr_r;
   logic [31:0] hit_cnt_r;
   logic [31:0] miss_cnt_r;

   // ***************************************
   // lookup
   // ***************************************
   logic conflict;
   logic [IW-1:0] set_idx;
   logic hit0;
   logic hit1;
   logic fwd_hit;
   logic pend_match;
   logic lookup_hit;
   logic load_ok;
   logic do_flush;

   assign conflict = addr_stage_pm_access & fetch1_req;
   assign set_idx = fetch1_addr[IW-1:0];
   assign hit0 = valid0_r[set_idx] & (tag0_r[set_idx] == fetch1_addr);
   assign hit1 = valid1_r[set_idx] & (tag1_r[set_idx] == fetch1_addr);
   assign pend_match = pend_r & (pend_addr_r == fetch1_addr);
   // write not finished yet: only the load bus has the instruction
   assign fwd_hit = pend_match & load_valid & ~(hit0 | hit1);
   assign lookup_hit = hit0 | hit1 | fwd_hit;
   assign load_ok = enable_r & ~freeze_r;
   assign do_flush = flush_cache | flush_sw_r;

   assign data_priority = addr_stage_pm_access;
   assign fetch_postpone = conflict;
   assign pipe_stall = conflict & ~lookup_hit;

   // hit data read in the lookup cycle, presented in fetch2
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cache_instr_valid <= 1'b0;
         cache_instr <= '0;
      end else begin
         cache_instr_valid <= conflict & lookup_hit;
         if (conflict & hit0) begin
            cache_instr <= data0_r[set_idx];
         end else if (conflict & hit1) begin
            cache_instr <= data1_r[set_idx];
         end else if (conflict & fwd_hit) begin
            cache_instr <= load_instr;
         end
      end
   end

   // a postponed fetch that missed goes to memory one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         refetch_req <= 1'b0;
         refetch_addr <= '0;
      end else begin
         refetch_req <= pipe_stall;
         if (pipe_stall) begin
            refetch_addr <= fetch1_addr;
         end
      end
   end

   // ***************************************
   // fill tracking
   // ***************************************
   // one outstanding fill; a second miss meanwhile is not cached
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_r <= 1'b0;
         pend_way_r <= 1'b0;
         pend_addr_r <= '0;
      end else if (do_flush) begin
         pend_r <= 1'b0;
      end else if (pend_r & load_valid) begin
         pend_r <= 1'b0;
      end else if (pipe_stall & ~pend_r & load_ok) begin
         pend_r <= 1'b1;
         pend_addr_r <= fetch1_addr;
         pend_way_r <= lru_r[set_idx];
      end
   end

   logic fill;
   logic [IW-1:0] fill_idx;
   assign fill = pend_r & load_valid & load_ok & ~do_flush;
   assign fill_idx = pend_addr_r[IW-1:0];

   always_ff @(posedge aclk) begin
      if (fill & ~pend_way_r) begin
         tag0_r[fill_idx] <= pend_addr_r;
         data0_r[fill_idx] <= load_instr;
      end
      if (fill & pend_way_r) begin
         tag1_r[fill_idx] <= pend_addr_r;
         data1_r[fill_idx] <= load_instr;
      end
   end

   // valid bits: flush takes effect at the next edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         valid0_r <= '0;
         valid1_r <= '0;
      end else if (do_flush) begin
         valid0_r <= '0;
         valid1_r <= '0;
      end else if (fill) begin
         if (pend_way_r) begin
            valid1_r[fill_idx] <= 1'b1;
         end else begin
            valid0_r[fill_idx] <= 1'b1;
         end
      end
   end

   // replacement bits; a fill outranks a hit to the same set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lru_r <= '0;
      end else begin
         if (conflict & (hit0 | hit1)) begin
            lru_r[set_idx] <= hit0;
         end
         if (fill) begin
            lru_r[fill_idx] <= ~pend_way_r;
         end
      end
   end

   // ***************************************
   // statistics
   // ***************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit_cnt_r <= '0;
         miss_cnt_r <= '0;
      end else begin
         if (conflict & lookup_hit) begin
            hit_cnt_r <= hit_cnt_r + 32'h1;
         end
         if (pipe_stall) begin
            miss_cnt_r <= miss_cnt_r + 32'h1;
         end
      end
   end

   // ***************************************
   // axi4-lite write path
   // ***************************************
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go;

   assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
   assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   logic wr_ctrl;
   assign wr_ctrl = wr_go & (awaddr_r[7:2] == conflict_cache_pkg::CTRL_OFF[7:2]) & wstrb_r[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_r <= conflict_cache_pkg::CTRL_RESET[conflict_cache_pkg::CTRL_ENABLE_BIT];
         freeze_r <= conflict_cache_pkg::CTRL_RESET[conflict_cache_pkg::CTRL_FREEZE_BIT];
         flush_sw_r <= 1'b0;
      end else begin
         flush_sw_r <= 1'b0;
         if (wr_ctrl) begin
            enable_r <= wdata_r[conflict_cache_pkg::CTRL_ENABLE_BIT];
            freeze_r <= wdata_r[conflict_cache_pkg::CTRL_FREEZE_BIT];
            // flush works whatever the enable bit says
            flush_sw_r <= wdata_r[conflict_cache_pkg::CTRL_FLUSH_BIT];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= conflict_cache_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         if (awaddr_r[7:2] == conflict_cache_pkg::CTRL_OFF[7:2]) begin
            s_axi_bresp <= conflict_cache_pkg::RESP_OKAY;
         end else if (awaddr_r[7:2] == conflict_cache_pkg::STATUS_OFF[7:2]) begin
            s_axi_bresp <= conflict_cache_pkg::RESP_OKAY;
         end else if (awaddr_r[7:2] == conflict_cache_pkg::HIT_CNT_OFF[7:2]) begin
            s_axi_bresp <= conflict_cache_pkg::RESP_OKAY;
         end else if (awaddr_r[7:2] == conflict_cache_pkg::MISS_CNT_OFF[7:2]) begin
            s_axi_bresp <= conflict_cache_pkg::RESP_OKAY;
         end else begin
            s_axi_bresp <= conflict_cache_pkg::RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ***************************************
   // axi4-lite read path
   // ***************************************
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= conflict_cache_pkg::RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= conflict_cache_pkg::RESP_OKAY;
         s_axi_rdata <= '0;
         if (s_axi_araddr[7:2] == conflict_cache_pkg::CTRL_OFF[7:2]) begin
            s_axi_rdata[conflict_cache_pkg::CTRL_ENABLE_BIT] <= enable_r;
            s_axi_rdata[conflict_cache_pkg::CTRL_FREEZE_BIT] <= freeze_r;
         end else if (s_axi_araddr[7:2] == conflict_cache_pkg::STATUS_OFF[7:2]) begin
            s_axi_rdata[conflict_cache_pkg::STAT_PEND_BIT] <= pend_r;
            s_axi_rdata[conflict_cache_pkg::STAT_PEND_WAY_BIT] <= pend_way_r;
         end else if (s_axi_araddr[7:2] == conflict_cache_pkg::HIT_CNT_OFF[7:2]) begin
            s_axi_rdata <= hit_cnt_r;
         end else if (s_axi_araddr[7:2] == conflict_cache_pkg::MISS_CNT_OFF[7:2]) begin
            s_axi_rdata <= miss_cnt_r;
         end else begin
            s_axi_rresp <= conflict_cache_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* File: rtl/conflict_cache_pkg.sv */
`default_nettype none
package conflict_cache_pkg;

   // ***************************************
   // geometry
   // ***************************************
   localparam int unsigned NUM_SETS = 16;
   localparam int unsigned NUM_WAYS = 2;
   localparam int unsigned SET_IDX_W = 4;
   localparam int unsigned DEF_ADDR_W = 24;
   localparam int unsigned DEF_INSTR_W = 48;

   // ***************************************
   // register map (byte addresses)
   // ***************************************
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] HIT_CNT_OFF = 8'h08;
   localparam logic [7:0] MISS_CNT_OFF = 8'h0c;

   // core_mode_control_two style control bits
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam int unsigned CTRL_FREEZE_BIT = 1;
   localparam int unsigned CTRL_FLUSH_BIT = 2;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // status bits
   localparam int unsigned STAT_PEND_BIT = 0;
   localparam int unsigned STAT_PEND_WAY_BIT = 1;

   // ***************************************
   // bus answers
   // ***************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* File: test/cache_conflict_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module cache_conflict_checker #(
   parameter int unsigned ADDR_W = 24
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // sequencer side
   input wire logic fetch1_req,
   input wire logic [ADDR_W-1:0] fetch1_addr,
   input wire logic addr_stage_pm_access,
   input wire logic data_priority,
   input wire logic fetch_postpone,
   input wire logic pipe_stall,
   input wire logic refetch_req,
   input wire logic [ADDR_W-1:0] refetch_addr,
   input wire logic cache_instr_valid
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   data_first_a: assert property (data_priority == addr_stage_pm_access)
      else $error("bus not handed to data access");
   conflict_seen_a: assert property (fetch_postpone == (fetch1_req && addr_stage_pm_access))
      else $error("conflict flag wrong");
   stall_cause_a: assert property (pipe_stall |-> fetch_postpone)
      else $error("stall without conflict");
   miss_refetch_a: assert property (pipe_stall |=> refetch_req && refetch_addr == $past(fetch1_addr))
      else $error("miss not refetched next cycle");
   refetch_origin_a: assert property (refetch_req |-> $past(pipe_stall))
      else $error("refetch without stall");
   hit_answer_a: assert property (fetch_postpone && !pipe_stall |=> cache_instr_valid)
      else $error("hit gave no instruction");
   hit_origin_a: assert property (cache_instr_valid |-> $past(fetch_postpone) && !$past(pipe_stall))
      else $error("instruction without hitting lookup");
   quiet_idle_a: assert property (!fetch_postpone |-> !pipe_stall ##1 !refetch_req && !cache_instr_valid)
      else $error("activity without conflict");
   miss_c: cover property (pipe_stall ##1 refetch_req);
   hit_c: cover property (fetch_postpone && !pipe_stall ##1 cache_instr_valid);
   data_only_c: cover property (addr_stage_pm_access && !fetch1_req);
endmodule
bind conflict_instruction_cache cache_conflict_checker #(.ADDR_W(ADDR_W)) chk_i (.aclk, .aresetn,
   .fetch1_req, .fetch1_addr, .addr_stage_pm_access, .data_priority, .fetch_postpone, .pipe_stall,
   .refetch_req, .refetch_addr, .cache_instr_valid);
`default_nettype wire

/* File: test/program_memory_model.sv */
`timescale 1ns/10ps
`default_nettype none
module program_memory_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // answer speed
   input wire logic slow,
   // refetch and load
   input wire logic refetch_req,
   input wire logic [23:0] refetch_addr,
   output logic load_valid,
   output logic [47:0] load_instr
);
   logic [23:0] addr_r;
   logic [2:0] cnt_r;
   // idle bus toggles so stale words never look valid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_valid <= 1'b0;
         load_instr <= 48'h0;
         cnt_r <= 3'h0;
      end else begin
         load_valid <= 1'b0;
         load_instr <= ~load_instr;
         if (refetch_req && !slow) begin
            load_valid <= 1'b1;
            load_instr <= {refetch_addr, ~refetch_addr};
         end else if (refetch_req) begin
            addr_r <= refetch_addr;
            cnt_r <= 3'h3;
         end else if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
            if (cnt_r == 3'h1) begin
               load_valid <= 1'b1;
               load_instr <= {addr_r, ~addr_r};
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: test/conflict_instruction_cache_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module conflict_instruction_cache_tb;
   localparam logic [7:0] CTRL = conflict_cache_pkg::CTRL_OFF;
   localparam logic [1:0] OK = conflict_cache_pkg::RESP_OKAY;
   localparam logic [23:0] X0 = 24'h000013;
   localparam logic [23:0] X1 = 24'h000023;
   localparam logic [23:0] X2 = 24'h000033;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic fetch1_req = 1'b0, addr_stage_pm_access = 1'b0, flush_cache = 1'b0, slow = 1'b0;
   logic [23:0] fetch1_addr = 24'h0, refetch_addr;
   logic data_priority, fetch_postpone, pipe_stall, refetch_req, cache_instr_valid, load_valid;
   logic [47:0] cache_instr, load_instr;
   int errors = 0;
   int checks_done = 0;
   conflict_instruction_cache uut (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .fetch1_req(fetch1_req),
      .fetch1_addr(fetch1_addr),
      .addr_stage_pm_access(addr_stage_pm_access),
      .flush_cache(flush_cache),
      .data_priority(data_priority),
      .fetch_postpone(fetch_postpone),
      .pipe_stall(pipe_stall),
      .refetch_req(refetch_req),
      .refetch_addr(refetch_addr),
      .cache_instr_valid(cache_instr_valid),
      .cache_instr(cache_instr),
      .load_valid(load_valid),
      .load_instr(load_instr)
   );
   program_memory_model pmem (
      .aclk(aclk),
      .aresetn(aresetn),
      .slow(slow),
      .refetch_req(refetch_req),
      .refetch_addr(refetch_addr),
      .load_valid(load_valid),
      .load_instr(load_instr)
   );
   always #4 aclk = ~aclk;
   // ***************************************
   // tasks
   // ***************************************
   task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic lapse();
      errors++;
      $display("[FAIL] bus answer expected 1 seen 0");
      complete_run();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         #1;
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) begin
            s_axi_bready <= 1'b0;
            chk("bresp", er, r);
            return;
         end
      end
      lapse();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ar, rv;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         #1;
         ar = s_axi_arvalid & s_axi_arready;
         rv = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (rv) begin
            s_axi_rready <= 1'b0;
            chk("rdata", ed, d);
            chk("rresp", er, r);
            return;
         end
      end
      lapse();
   endtask
   // one conflict cycle, then the fetch2 answer
   task automatic cf(input logic [23:0] a, input logic hit);
      @(posedge aclk);
      fetch1_req <= 1'b1;
      addr_stage_pm_access <= 1'b1;
      fetch1_addr <= a;
      #1;
      chk("pipe_stall", !hit, pipe_stall);
      @(posedge aclk);
      fetch1_req <= 1'b0;
      addr_stage_pm_access <= 1'b0;
      #1;
      chk("answer_kind", {hit, !hit}, {cache_instr_valid, refetch_req});
      chk("answer_value", hit ? {a, ~a} : {24'h0, a}, hit ? cache_instr : {24'h0, refetch_addr});
   endtask
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge aclk);
         fetch1_req <= 1'b1;
         addr_stage_pm_access <= 1'b0;
      end
   endtask
   // ***************************************
   // sequence
   // ***************************************
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CTRL, 32'h0, OK);
      rd(conflict_cache_pkg::STATUS_OFF, 32'h0, OK);
      cf(X0, 1'b0);
      idle(3);
      cf(X0, 1'b0);
      $display("test disabled done");
      wr(CTRL, 32'h1, OK);
      rd(CTRL, 32'h1, OK);
      wr(8'h10, 32'h1, conflict_cache_pkg::RESP_SLVERR);
      rd(8'h10, 32'h0, conflict_cache_pkg::RESP_SLVERR);
      $display("test registers done");
      slow <= 1'b1;
      cf(X0, 1'b0);
      rd(conflict_cache_pkg::STATUS_OFF, 32'h1, OK);
      idle(6);
      slow <= 1'b0;
      cf(X1, 1'b0);
      cf(X1, 1'b1);
      idle(2);
      cf(X1, 1'b1);
      cf(X0, 1'b1);
      cf(X2, 1'b0);
      idle(2);
      cf(X0, 1'b1);
      cf(X1, 1'b0);
      idle(2);
      cf(24'h000014, 1'b0);
      idle(2);
      cf(X0, 1'b1);
      $display("test replacement done");
      wr(CTRL, 32'h3, OK);
      cf(24'h000044, 1'b0);
      idle(2);
      cf(24'h000044, 1'b0);
      wr(CTRL, 32'h1, OK);
      $display("test freeze done");
      @(posedge aclk);
      flush_cache <= 1'b1;
      @(posedge aclk);
      flush_cache <= 1'b0;
      cf(X0, 1'b0);
      idle(2);
      cf(X0, 1'b1);
      rd(conflict_cache_pkg::HIT_CNT_OFF, 32'h6, OK);
      rd(conflict_cache_pkg::MISS_CNT_OFF, 32'ha, OK);
      wr(CTRL, 32'h5, OK);
      cf(X0, 1'b0);
      @(posedge aclk);
      fetch1_req <= 1'b0;
      addr_stage_pm_access <= 1'b1;
      #1;
      chk("data_priority", 1'b1, data_priority);
      $display("test flush done");
      @(posedge aclk);
      aresetn <= 1'b0;
      addr_stage_pm_access <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      cf(X0, 1'b0);
      rd(CTRL, 32'h0, OK);
      $display("test second reset done");
      complete_run();
   end
endmodule
`default_nettype wire
